// *** dv/mta_ext_model.sv ***
/*
 * Far-side model: the timer input pins and the LIN receive line.
 * Assumes its tasks are called at a falling edge of clk_i.
 */
`timescale 1ns/100ps
module mta_ext_model (
	input  wire       clk_i,
	output reg  [7:0] pin_o,
	output reg        lin_o
);
	// The LIN line idles recessive high between frames.
	initial begin
		pin_o = 8'h00;
		lin_o = 1'b1;
	end
	task automatic pulse(input integer ch, input integer hi, input integer lo);
		begin
			pin_o[ch] = 1'b1;
			repeat (hi) @(negedge clk_i);
			pin_o[ch] = 1'b0;
			repeat (lo) @(negedge clk_i);
		end
	endtask
	task automatic lin_low(input integer lo, input integer hi);
		begin
			lin_o = 1'b0;
			repeat (lo) @(negedge clk_i);
			lin_o = 1'b1;
			repeat (hi) @(negedge clk_i);
		end
	endtask
endmodule // mta_ext_model

// *** dv/mta_timer_array_sva.sv ***
/*
 * Checker on the timer array top ports.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/100ps
module mta_timer_array_sva #(
	parameter UNIT0_CH = 8,
	parameter UNIT1_CH = 4,
	parameter [15:0] PRESCALE = 16'h000a,
	parameter N = UNIT0_CH + UNIT1_CH
) (
	input wire              REF_CLK_I,
	input wire              RST_I,
	input wire [1:0]        UNIT_EN_I,
	input wire [N-1:0]      CH_START_I,
	input wire [N*4-1:0]    CH_MODE_I,
	input wire [N*16-1:0]   CH_DATA_I,
	input wire [N-1:0]      CHANNEL_TIMER_INTERRUPT_O,
	input wire [UNIT0_CH-1:0] CHANNEL_OUTPUT_PIN_O,
	input wire [N*16-1:0]   CH_COUNT_O,
	input wire [N*16-1:0]   CH_CAPTURE_O,
	input wire [1:0]        LIN_STATE_O
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	wire [N-1:0] irq = CHANNEL_TIMER_INTERRUPT_O;
	reg  [19:0]  gap;
	reg          seen;
	// Cycles since the last pulse of channel 8, restarted when it stops.
	always @(posedge REF_CLK_I) begin
		if (RST_I || !UNIT_EN_I[1] || !CH_START_I[8]) begin
			gap <= 20'h00000;
			seen <= 1'b0;
		end else if (irq[8]) begin
			gap <= 20'h00001;
			seen <= 1'b1;
		end else begin
			gap <= gap + 20'h00001;
		end
	end
	chk_rst_count: assert property (disable iff (1'b0)
		RST_I |=> CH_COUNT_O == {N{16'hffff}})
		else $error("count not all ones after reset");
	chk_rst_quiet: assert property (disable iff (1'b0)
		RST_I |=> irq == 0 && CH_CAPTURE_O == 0 && LIN_STATE_O == 2'h0)
		else $error("outputs not cleared by reset");
	chk_unit_off: assert property (!UNIT_EN_I[1] |=>
		CH_COUNT_O[UNIT0_CH*16 +: UNIT1_CH*16] == {UNIT1_CH{16'hffff}})
		else $error("disabled unit count not all ones");
	chk_off_silent: assert property ($fell(UNIT_EN_I[1]) |=>
		(irq[UNIT0_CH +: UNIT1_CH] == 0) [*3])
		else $error("interrupt from a disabled unit");
	chk_irq_single: assert property (
		!(|(irq[UNIT0_CH +: UNIT1_CH] & $past(irq[UNIT0_CH +: UNIT1_CH]))))
		else $error("interrupt longer than one cycle");
	chk_int_period: assert property (irq[8] && seen |->
		gap == {4'h0, PRESCALE} * ({4'h0, CH_DATA_I[143:128]} + 20'h1))
		else $error("interval period wrong");
	chk_sq_toggle: assert property (CH_MODE_I[3:0] == 4'h1 &&
		$changed(CHANNEL_OUTPUT_PIN_O[0]) |-> irq[0])
		else $error("square output moved without interrupt");
	chk_cap_irq: assert property ($changed(CH_CAPTURE_O[79:64]) |-> irq[4])
		else $error("capture without interrupt");
	chk_lin_order: assert property ($changed(LIN_STATE_O) |->
		LIN_STATE_O == $past(LIN_STATE_O) + 2'h1 || LIN_STATE_O == 2'h0)
		else $error("LIN state skipped a step");
endmodule // mta_timer_array_sva
bind mta_timer_array mta_timer_array_sva #(.UNIT0_CH(UNIT0_CH),
	.UNIT1_CH(UNIT1_CH), .PRESCALE(PRESCALE)) u_sva (
	.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .UNIT_EN_I(UNIT_EN_I),
	.CH_START_I(CH_START_I), .CH_MODE_I(CH_MODE_I), .CH_DATA_I(CH_DATA_I),
	.CHANNEL_TIMER_INTERRUPT_O(CHANNEL_TIMER_INTERRUPT_O),
	.CHANNEL_OUTPUT_PIN_O(CHANNEL_OUTPUT_PIN_O), .CH_COUNT_O(CH_COUNT_O),
	.CH_CAPTURE_O(CH_CAPTURE_O), .LIN_STATE_O(LIN_STATE_O));

// *** dv/mta_timer_array_tb.sv ***
/*
 * Self-checking bench for the timer array with random periods and widths.
 * Assumes the prescaler is shortened to two clocks.
 */
`timescale 1ns/100ps
module mta_timer_array_tb;
	localparam integer P = 2;
	reg          clk;
	reg          rst;
	reg  [1:0]   en;
	reg  [11:0]  start;
	reg  [47:0]  mode;
	reg  [191:0] data;
	reg  [31:0]  r;
	reg          o;
	wire [7:0]   pin;
	wire         lin;
	wire [11:0]  irq;
	wire [7:0]   outp;
	wire [191:0] cnt;
	wire [191:0] cap;
	wire [1:0]   state;
	wire [19:0]  watch = {outp, irq};
	integer      n_errors, n_tests, seed, k, ch, c, s;
	mta_ext_model ext (.clk_i(clk), .pin_o(pin), .lin_o(lin));
	mta_timer_array #(.PRESCALE(16'h0002)) dut (
		.REF_CLK_I(clk), .RST_I(rst), .UNIT_EN_I(en), .CH_START_I(start),
		.CH_RISE_I(12'hfff), .CH_MODE_I(mode), .CH_DATA_I(data),
		.TIMER_IN_I(pin), .LIN_SERIAL_RECEIVE_LINE_I(lin),
		.CHANNEL_TIMER_INTERRUPT_O(irq), .CHANNEL_OUTPUT_PIN_O(outp),
		.CH_COUNT_O(cnt), .CH_CAPTURE_O(cap), .LIN_STATE_O(state));
	function integer per(input integer v);
		per = P * (v + 1);
	endfunction
	task check(input [191:0] got, input [191:0] want);
		begin
			n_tests = n_tests + 1;
			if (got !== want) begin
				n_errors = n_errors + 1;
				$display("mismatch at %0t: got %0h want %0h", $time, got, want);
			end
		end
	endtask
	task stop_test;
		begin
			$display("errors %0d checks %0d", n_errors, n_tests);
			if (n_errors == 0 && n_tests > 0) begin
				$display("All checks passed");
			end else begin
				$display("Checks failed");
			end
			$finish;
		end
	endtask
	// Every wait is bounded so a dead channel ends the run.
	task wait_on(input integer i, input v, output integer n);
		begin
			n = 0;
			while (watch[i] !== v) begin
				@(negedge clk);
				n = n + 1;
				if (n > 4000) begin
					n_errors = n_errors + 1;
					$display("mismatch at %0t: wait timed out", $time);
					stop_test;
				end
			end
			@(negedge clk);
		end
	endtask
	task widths(input integer i, input integer hi, input integer lo);
		begin
			wait_on(i, 1'b1, c);
			wait_on(i, 1'b0, c);
			wait_on(i, 1'b1, c);
			check(c + 1, lo);
			wait_on(i, 1'b0, c);
			check(c + 1, hi);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		n_errors = 0;
		n_tests = 0;
		seed = 32'hc569;
		rst = 1'b1;
		en = 2'b00;
		start = 12'h000;
		mode = 48'h0;
		data = 192'h0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check(cnt, {12{16'hffff}});
		check(cap, 192'h0);
		for (k = 0; k < 12; k = k + 1) begin
			r = $random(seed);
			mode[k*4 +: 4] = r[7:4];
			data[k*16 +: 16] = {13'h0, r[2:0]} + 16'h0001;
		end
		mode[31:0] = 32'h92547631;
		data[47:32] = 16'h0007;
		data[63:48] = {14'h0, r[1:0]} + 16'h0001;
		en = 2'b11;
		start = 12'hfff;
		for (k = 8; k < 13; k = k + 1) begin
			ch = (k == 12) ? 1 : k;
			wait_on(ch, 1'b1, c);
			wait_on(ch, 1'b1, c);
			check(c + 1, per(data[ch*16 +: 16]));
		end
		widths(12, per(data[15:0]), per(data[15:0]));
		// The slave rises one clock after the master interrupt and falls
		// on its own last tick, so it is high one clock short of DATA+1 ticks.
		widths(15, per(data[63:48]) - 1, per(7) - per(data[63:48]) + 1);
		for (k = 0; k < data[111:96]; k = k + 1) begin
			ext.pulse(6, 3, 3);
		end
		check(cnt[111:96], 16'h0000);
		ext.pulse(6, 3, 3);
		check(cnt[111:96], data[111:96]);
		r = $random(seed);
		s = 2 * (r[3:0] + 4) + 1;
		repeat (3) ext.pulse(4, 5, s - 5);
		check(cap[79:64], (s - 1) / P);
		s = 2 * (r[7:4] + 3) + 1;
		ext.pulse(5, s, 8);
		check(cap[95:80], (s - 1) / P);
		ext.lin_low(100, 10);
		check(state, 2'h0);
		ext.lin_low(320, 10);
		check(state, 2'h1);
		ext.lin_low(20, 10);
		check(state, 2'h1);
		ext.lin_low(40, 10);
		check(state, 2'h2);
		repeat (4) ext.lin_low(10, 10);
		check(state, 2'h2);
		ext.lin_low(10, 10);
		check(state, 2'h3);
		// Channel 0 is stopped and restarted as a divider on its pin.
		start[0] = 1'b0;
		mode[3:0] = 4'h3;
		r = $random(seed);
		data[15:0] = {13'h0, r[2:0]} + 16'h0001;
		@(negedge clk);
		start[0] = 1'b1;
		@(negedge clk);
		o = outp[0];
		for (k = 0; k < data[15:0]; k = k + 1) begin
			ext.pulse(0, 3, 3);
		end
		check(outp[0], o);
		ext.pulse(0, 3, 3);
		o = ~o;
		check(outp[0], o);
		// Channel 2 becomes a one-shot master; channel 3 stays its slave.
		start[2] = 1'b0;
		mode[11:8] = 4'h8;
		data[47:32] = {13'h0, r[5:3]} + 16'h0002;
		@(negedge clk);
		start[2] = 1'b1;
		repeat (20) @(negedge clk);
		check(outp[3], 1'b0);
		ext.pulse(2, 3, 3);
		wait_on(15, 1'b1, c);
		wait_on(15, 1'b0, c);
		check(c + 1, per(data[63:48]) - 1);
		repeat (40) @(negedge clk);
		check(outp[3], 1'b0);
		en = 2'b01;
		repeat (4) @(negedge clk);
		check(cnt[191:128], {4{16'hffff}});
		stop_test;
	end
endmodule // mta_timer_array_tb

// *** logic/mta_consts.vh ***
/*
 * Constants of the multi-channel timer array: counter width and reset
 * value, mode codes, prescaler and LIN measurement defaults.
 * Assumes inclusion by the timer array module only.
 */
`ifndef MTA_CONSTS_VH
`define MTA_CONSTS_VH

`define MTA_CNT_W        16
`define MTA_CNT_RST      16'hffff
`define MTA_MODE_W       4

`define MTA_MD_INTERVAL  4'h0
`define MTA_MD_SQUARE    4'h1
`define MTA_MD_EVENT     4'h2
`define MTA_MD_DIVIDER   4'h3
`define MTA_MD_PULSE     4'h4
`define MTA_MD_LEVEL     4'h5
`define MTA_MD_PWM_MST   4'h6
`define MTA_MD_SLAVE     4'h7
`define MTA_MD_ONE_MST   4'h8
`define MTA_MD_LIN       4'h9

`define MTA_UNIT0_CH     8
`define MTA_UNIT1_CH     4
`define MTA_DIV_OK       8'h1d
`define MTA_LIN_CH       7

`define MTA_PRESCALE     16'h000a
`define MTA_LIN_WAKE_MIN 16'h0096
`define MTA_LIN_BRK_MIN  16'h000b
`define MTA_LIN_SYNC_N   4'h8

`define MTA_LIN_WAKE     2'h0
`define MTA_LIN_BREAK    2'h1
`define MTA_LIN_SYNC     2'h2
`define MTA_LIN_DONE     2'h3

`endif

// *** logic/mta_timer_array.v ***
/*
 * Multi-channel timer array: two units of 16-bit channels, unit 0 with single
 * and master/slave modes, unit 1 with interval timers only, and LIN wakeup, break and sync measurement.
 * Assumes configuration straps held steady while a channel runs, and
 * external timer inputs and the LIN line asynchronous to REF_CLK_I.
 */
`timescale 1ns/100ps
`include "mta_consts.vh"

module mta_timer_array #(
	parameter UNIT0_CH = `MTA_UNIT0_CH,
	parameter UNIT1_CH = `MTA_UNIT1_CH,
	parameter [15:0] PRESCALE = `MTA_PRESCALE,
	parameter [15:0] LIN_WAKE_MIN = `MTA_LIN_WAKE_MIN,
	parameter [15:0] LIN_BRK_MIN = `MTA_LIN_BRK_MIN,
	parameter [3:0] LIN_SYNC_N = `MTA_LIN_SYNC_N
) (
	// Clock and reset.
	input  wire                          REF_CLK_I,
	input  wire                          RST_I,
	// Unit enables and per-channel control.
	input  wire [1:0]                    UNIT_EN_I,
	input  wire [UNIT0_CH+UNIT1_CH-1:0]  CH_START_I,
	input  wire [UNIT0_CH+UNIT1_CH-1:0]  CH_RISE_I,
	input  wire [(UNIT0_CH+UNIT1_CH)*4-1:0]  CH_MODE_I,
	input  wire [(UNIT0_CH+UNIT1_CH)*16-1:0] CH_DATA_I,
	// External pins.
	input  wire [UNIT0_CH-1:0]           TIMER_IN_I,
	input  wire                          LIN_SERIAL_RECEIVE_LINE_I,
	// Results.
	output wire [UNIT0_CH+UNIT1_CH-1:0]  CHANNEL_TIMER_INTERRUPT_O,
	output wire [UNIT0_CH-1:0]           CHANNEL_OUTPUT_PIN_O,
	output wire [(UNIT0_CH+UNIT1_CH)*16-1:0] CH_COUNT_O,
	output wire [(UNIT0_CH+UNIT1_CH)*16-1:0] CH_CAPTURE_O,
	output wire [1:0]                    LIN_STATE_O
);

	localparam NCH = UNIT0_CH + UNIT1_CH;
	localparam [7:0] DIV_OK = `MTA_DIV_OK;

	wire [NCH-1:0]    irqv;
	wire [NCH-1:0]    toutv;
	wire [NCH-1:0]    trig;
	wire [NCH-1:0]    is_master;
	wire [NCH-1:0]    is_slave;
	wire [NCH*16-1:0] capv;
	wire [NCH*4-1:0]  effv;

	reg  [15:0]       pre_cnt;
	reg               tick;
	reg               rx1;
	reg               rx2;
	reg               rx3;
	reg               rx_lvl;
	reg  [1:0]        lin_state;
	reg  [3:0]        sync_cnt;

	wire rx_agree = (rx2 == rx3);
	wire rx_rise  = rx_agree & rx3 & ~rx_lvl;
	wire rx_fall  = rx_agree & ~rx3 & rx_lvl;
	wire lin_on   = (effv[`MTA_LIN_CH*4 +: 4] == `MTA_MD_LIN) &
		CH_START_I[`MTA_LIN_CH] & UNIT_EN_I[0];
	wire lin_cap  = irqv[`MTA_LIN_CH] & lin_on;
	wire lin_sync = (lin_state == `MTA_LIN_SYNC);

	// Shared prescaler: one enable pulse every PRESCALE clocks.
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			pre_cnt <= 16'h0000;
			tick    <= 1'b0;
		end else if (pre_cnt >= PRESCALE - 16'h0001) begin
			pre_cnt <= 16'h0000;
			tick    <= 1'b1;
		end else begin
			pre_cnt <= pre_cnt + 16'h0001;
			tick    <= 1'b0;
		end
	end

	// The LIN line idles high, so the filter starts high to avoid a
	// false falling edge right after reset.
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			rx1    <= 1'b1;
			rx2    <= 1'b1;
			rx3    <= 1'b1;
			rx_lvl <= 1'b1;
		end else begin
			rx1 <= LIN_SERIAL_RECEIVE_LINE_I;
			rx2 <= rx1;
			rx3 <= rx2;
			if (rx_agree)
				rx_lvl <= rx3;
		end
	end

	// LIN sequence: wakeup, then sync break, then sync field widths.
	always @(posedge REF_CLK_I) begin
		if (RST_I || !lin_on) begin
			lin_state <= `MTA_LIN_WAKE;
			sync_cnt  <= 4'h0;
		end else if (lin_cap) begin
			case (lin_state)
			`MTA_LIN_WAKE: begin
				if (capv[`MTA_LIN_CH*16 +: 16] > LIN_WAKE_MIN)
					lin_state <= `MTA_LIN_BREAK;
			end
			`MTA_LIN_BREAK: begin
				if (capv[`MTA_LIN_CH*16 +: 16] > LIN_BRK_MIN) begin
					lin_state <= `MTA_LIN_SYNC;
					sync_cnt  <= 4'h0;
				end
			end
			`MTA_LIN_SYNC: begin
				sync_cnt <= sync_cnt + 4'h1;
				if (sync_cnt == LIN_SYNC_N - 4'h1)
					lin_state <= `MTA_LIN_DONE;
			end
			default: begin
				lin_state <= lin_state;
			end
			endcase
		end
	end

	assign LIN_STATE_O = lin_state;
	assign CHANNEL_TIMER_INTERRUPT_O = irqv;
	assign CHANNEL_OUTPUT_PIN_O = toutv[UNIT0_CH-1:0];
	assign CH_CAPTURE_O = capv;

	genvar n;
	generate
		for (n = 0; n < NCH; n = n + 1) begin : g_ch
			wire [3:0]  req  = CH_MODE_I[n*4 +: 4];
			wire [15:0] data = CH_DATA_I[n*16 +: 16];
			wire        unit_en = (n < UNIT0_CH) ? UNIT_EN_I[0]
				: UNIT_EN_I[1];
			wire        run = CH_START_I[n] & unit_en;
			reg  [3:0]  mode;
			reg  [15:0] cnt;
			reg  [15:0] cap;
			reg         irq;
			reg         tout;
			reg         busy;
			reg         meas;
			reg         run_d;
			reg         start_ev;
			reg         stop_ev;
			reg         restart;
			wire        p_rise;
			wire        p_fall;

			// Unsupported functions fall back to the interval timer.
			always @* begin
				mode = req;
				if (n >= UNIT0_CH)
					mode = `MTA_MD_INTERVAL;
				else if (req == `MTA_MD_DIVIDER &&
					((DIV_OK >> n) & 8'h01) == 8'h00)
					mode = `MTA_MD_INTERVAL;
				else if (req == `MTA_MD_LIN && n != `MTA_LIN_CH)
					mode = `MTA_MD_INTERVAL;
				else if (req > `MTA_MD_LIN)
					mode = `MTA_MD_INTERVAL;
			end

			if (n < UNIT0_CH) begin : g_pin
				reg s1;
				reg s2;
				reg s3;
				reg lvl;
				always @(posedge REF_CLK_I) begin
					if (RST_I) begin
						s1  <= 1'b0;
						s2  <= 1'b0;
						s3  <= 1'b0;
						lvl <= 1'b0;
					end else begin
						s1 <= TIMER_IN_I[n];
						s2 <= s1;
						s3 <= s2;
						if (s2 == s3)
							lvl <= s3;
					end
				end
				assign p_rise = (s2 == s3) & s3 & ~lvl;
				assign p_fall = (s2 == s3) & ~s3 & lvl;
			end else begin : g_nopin
				assign p_rise = 1'b0;
				assign p_fall = 1'b0;
			end

			wire v_edge = CH_RISE_I[n] ? p_rise : p_fall;
			wire o_edge = CH_RISE_I[n] ? p_fall : p_rise;

			// Chain: a slave follows the nearest master below it only through an unbroken run of slaves.
			assign is_master[n] = (mode == `MTA_MD_PWM_MST) |
				(mode == `MTA_MD_ONE_MST);
			assign is_slave[n] = (mode == `MTA_MD_SLAVE);
			if (n == 0) begin : g_t0
				assign trig[n] = 1'b0;
			end else begin : g_tn
				assign trig[n] = is_master[n-1] ? irqv[n-1]
					: (is_slave[n-1] ? trig[n-1] : 1'b0);
			end

			always @* begin
				start_ev = v_edge;
				stop_ev  = v_edge;
				restart  = 1'b1;
				if (mode == `MTA_MD_LEVEL) begin
					stop_ev = o_edge;
					restart = 1'b0;
				end else if (mode == `MTA_MD_LIN) begin
					start_ev = lin_sync ? (rx_rise | rx_fall) : rx_fall;
					stop_ev  = lin_sync ? (rx_rise | rx_fall) : rx_rise;
					restart  = lin_sync;
				end
			end

			always @(posedge REF_CLK_I) begin
				irq   <= 1'b0;
				run_d <= run;
				if (RST_I || !unit_en) begin
					cnt   <= `MTA_CNT_RST;
					cap   <= 16'h0000;
					tout  <= 1'b0;
					busy  <= 1'b0;
					meas  <= 1'b0;
					run_d <= 1'b0;
				end else if (!run) begin
					busy <= 1'b0;
					meas <= 1'b0;
				end else if (!run_d) begin
					busy <= 1'b0;
					meas <= 1'b0;
					case (mode)
					`MTA_MD_PULSE, `MTA_MD_LEVEL, `MTA_MD_LIN,
					`MTA_MD_SLAVE: begin
						cnt <= 16'h0000;
					end
					`MTA_MD_PWM_MST: begin
						cnt <= data;
						irq <= 1'b1;
					end
					default: begin
						cnt <= data;
					end
					endcase
				end else begin
					case (mode)
					`MTA_MD_INTERVAL, `MTA_MD_SQUARE,
					`MTA_MD_PWM_MST: begin
						if (tick) begin
							if (cnt == 16'h0000) begin
								irq <= 1'b1;
								cnt <= data;
								if (mode == `MTA_MD_SQUARE)
									tout <= ~tout;
							end else begin
								cnt <= cnt - 16'h0001;
							end
						end
					end
					`MTA_MD_EVENT, `MTA_MD_DIVIDER: begin
						if (v_edge) begin
							if (cnt == 16'h0000) begin
								irq <= 1'b1;
								cnt <= data;
								if (mode == `MTA_MD_DIVIDER)
									tout <= ~tout;
							end else begin
								cnt <= cnt - 16'h0001;
							end
						end
					end
					`MTA_MD_ONE_MST: begin
						if (!busy && v_edge) begin
							cnt  <= data;
							busy <= 1'b1;
						end else if (busy && tick) begin
							if (cnt == 16'h0000) begin
								irq  <= 1'b1;
								busy <= 1'b0;
							end else begin
								cnt <= cnt - 16'h0001;
							end
						end
					end
					`MTA_MD_SLAVE: begin
						if (trig[n]) begin
							cnt  <= data;
							tout <= (data != 16'h0000);
							busy <= 1'b1;
						end else if (busy && tick) begin
							if (cnt == 16'h0000) begin
								irq  <= 1'b1;
								tout <= 1'b0;
								busy <= 1'b0;
							end else begin
								cnt <= cnt - 16'h0001;
							end
						end
					end
					`MTA_MD_PULSE, `MTA_MD_LEVEL, `MTA_MD_LIN: begin
						if (meas && stop_ev) begin
							cap  <= cnt;
							irq  <= 1'b1;
							cnt  <= 16'h0000;
							meas <= restart;
						end else if (!meas && start_ev) begin
							cnt  <= 16'h0000;
							meas <= 1'b1;
						end else if (meas && tick) begin
							cnt <= cnt + 16'h0001;
						end
					end
					default: begin
						cnt <= cnt;
					end
					endcase
				end
			end

			assign irqv[n] = irq;
			assign toutv[n] = tout;
			assign capv[n*16 +: 16] = cap;
			assign CH_COUNT_O[n*16 +: 16] = cnt;
			assign effv[n*4 +: 4] = mode;
		end
	endgenerate

endmodule // mta_timer_array
